// [fcm_pkg.sv]
/*
 * Constants and types for the fuse check mode controller.
 * Assumes a single 200 MHz clock and a synchronous active-low power-on reset.
 */
package fcm_pkg;

	// **************************************************
	// Pin sampling
	// **************************************************
	localparam int SYNC_W = 3;
	localparam int TMS_BIT = 0;
	localparam int TEST_BIT = 1;
	localparam int BLOWN_BIT = 2;
	// Select line idles high, fuse pin and blown status idle low
	localparam logic [SYNC_W-1:0] SYNC_RST = 3'h1;
	localparam logic TMS_PREV_RST = 1'h1;
	localparam logic TEST_PREV_RST = 1'h0;

	// **************************************************
	// Edge tracking
	// **************************************************
	localparam logic [1:0] RISE_CNT_RST = 2'h0;
	localparam logic [1:0] RISE_EXIT = 2'h2;

	typedef enum logic [1:0] {
		FCM_ARMED,
		FCM_ACTIVE,
		FCM_DONE
	} fcm_state_t;

endpackage : fcm_pkg

// [fcm_sync.sv]
/*
 * Two-stage synchronisers for the pin-level inputs of the fuse check controller.
 * Assumes the inputs are asynchronous to clk_i; reset values come from the package.
 */
`timescale 1ns/1ps

module fcm_sync (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [fcm_pkg::SYNC_W-1:0] async_i,
	output logic [fcm_pkg::SYNC_W-1:0] sync_o
);
	import fcm_pkg::*;

	logic [SYNC_W-1:0] meta_q;
	logic [SYNC_W-1:0] sync_q;

	// **************************************************
	// One synchroniser per bit
	// **************************************************
	for (genvar i = 0; i < SYNC_W; i++) begin : g_bit
		always_ff @(posedge clk_i) begin
			if (!rst_n_i) begin
				meta_q[i] <= SYNC_RST[i];
				sync_q[i] <= SYNC_RST[i];
			end else begin
				meta_q[i] <= async_i[i];
				sync_q[i] <= meta_q[i];
			end
		end
	end

	assign sync_o = sync_q;

endmodule : fcm_sync

// [fcm_ctrl.sv]
/*
 * Fuse check mode controller: tracks select-line edges after power-on reset and
 * gates the fuse sense current path; forces the debug port into bypass once blown.
 * Assumes rst_n_i is the power-on reset, and pins are asynchronous to clk_i.
 */
`timescale 1ns/1ps

module fcm_ctrl (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic tms_i,
	input wire logic test_pin_i,
	input wire logic fuse_blown_i,
	output logic fuse_check_active_o,
	output logic fuse_check_current_o,
	output logic debug_bypass_o,
	output logic debug_access_en_o
);
	import fcm_pkg::*;

	logic [SYNC_W-1:0] pin_s;
	logic tms_prev_q;
	logic test_prev_q;
	logic [1:0] rise_cnt_q;
	logic blown_q;
	logic blown_any;
	logic tms_fall;
	logic tms_rise;
	logic test_fall;
	fcm_state_t state_q;
	fcm_state_t state_d;
	logic active_q;
	logic cur_q;
	logic bypass_q;
	logic access_q;

	// **************************************************
	// Pin synchronisation and edge detection
	// **************************************************
	fcm_sync u_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.async_i({fuse_blown_i, test_pin_i, tms_i}),
		.sync_o(pin_s)
	);

	// Select resets high, so a line held low through reset shows as a first fall
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			tms_prev_q <= TMS_PREV_RST;
			test_prev_q <= TEST_PREV_RST;
		end else begin
			tms_prev_q <= pin_s[TMS_BIT];
			test_prev_q <= pin_s[TEST_BIT];
		end
	end

	assign tms_fall = tms_prev_q && !pin_s[TMS_BIT];
	assign tms_rise = !tms_prev_q && pin_s[TMS_BIT];
	assign test_fall = test_prev_q && !pin_s[TEST_BIT];

	// Rises counted from reset; saturates at the exit count
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rise_cnt_q <= RISE_CNT_RST;
		end else if (tms_rise && rise_cnt_q != RISE_EXIT) begin
			rise_cnt_q <= rise_cnt_q + 2'h1;
		end
	end

	// **************************************************
	// Fuse status
	// **************************************************
	assign blown_any = blown_q || pin_s[BLOWN_BIT];

	// A blown fuse cannot recover, so the flag is sticky
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			blown_q <= 1'h0;
		end else begin
			blown_q <= blown_any;
		end
	end

	// **************************************************
	// Mode state machine
	// **************************************************
	always_comb begin
		state_d = state_q;
		case (state_q)
			FCM_ARMED: begin
				if (blown_any) begin
					state_d = FCM_DONE;
				end else if (tms_fall) begin
					state_d = FCM_ACTIVE;
				end
			end
			FCM_ACTIVE: begin
				if (blown_any || test_fall) begin
					state_d = FCM_DONE;
				end else if (tms_rise && rise_cnt_q == RISE_EXIT - 2'h1) begin
					state_d = FCM_DONE;
				end
			end
			FCM_DONE: begin
				state_d = FCM_DONE;
			end
			default: begin
				state_d = FCM_DONE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_q <= FCM_ARMED;
		end else begin
			state_q <= state_d;
		end
	end

	// **************************************************
	// Outputs
	// **************************************************
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			active_q <= 1'h0;
			cur_q <= 1'h0;
		end else begin
			active_q <= (state_d == FCM_ACTIVE);
			// Sense path only while active, select low and fuse intact
			cur_q <= (state_d == FCM_ACTIVE) && !pin_s[TMS_BIT] && !blown_any;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			bypass_q <= 1'h0;
			access_q <= 1'h1;
		end else begin
			bypass_q <= blown_any;
			access_q <= !blown_any;
		end
	end

	assign fuse_check_active_o = active_q;
	assign fuse_check_current_o = cur_q;
	assign debug_bypass_o = bypass_q;
	assign debug_access_en_o = access_q;

	// **************************************************
	// Checks
	// **************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence por_release_s;
		$rose(rst_n_i);
	endsequence

	sequence held_low_s;
		(!tms_i && !fuse_blown_i && !test_pin_i) [*4];
	endsequence

	first_access_a: assert property (
		por_release_s ##0 held_low_s |=> fuse_check_active_o
	) else $error("held-low select did not activate fuse check");

	fall_enter_a: assert property (
		state_q == FCM_ARMED && tms_fall && !blown_any |=> fuse_check_active_o
	) else $error("first select fall did not activate fuse check");

	second_rise_a: assert property (
		state_q == FCM_ACTIVE && tms_rise && rise_cnt_q == 2'h1
		|=> state_q == FCM_DONE && !fuse_check_active_o
	) else $error("second select rise did not end fuse check");

	no_reentry_a: assert property (
		state_q == FCM_DONE |=> state_q == FCM_DONE && !fuse_check_active_o
	) else $error("fuse check re-entered before power-on reset");

	cur_gate_a: assert property (
		fuse_check_current_o |-> fuse_check_active_o && !$past(pin_s[TMS_BIT])
	) else $error("sense current without active mode and low select");

	blown_nocur_a: assert property (
		blown_q |-> !fuse_check_current_o
	) else $error("sense current drawn with blown fuse");

	test_low_end_a: assert property (
		state_q == FCM_ACTIVE && test_fall |=> !fuse_check_active_o && !fuse_check_current_o
	) else $error("fuse pin low did not end fuse check");

	bypass_hold_a: assert property (
		debug_bypass_o |=> (debug_bypass_o && !debug_access_en_o) [*3]
	) else $error("debug bypass released after fuse blow");

	por_idle_a: assert property (
		por_release_s |-> state_q == FCM_ARMED && !fuse_check_current_o && rise_cnt_q == 2'h0
	) else $error("reset did not leave tracking armed and idle");

endmodule : fcm_ctrl

// [fcm_tool.sv]
/*
 * Debug tool model driving the select line, fuse pin and blown status.
 * Assumes the bench calls drive() and that inputs change at the falling edge.
 */
`timescale 1ns/1ps

module fcm_tool (
	input wire logic clk_i,
	output logic tms_o,
	output logic test_pin_o,
	output logic blown_o
);
	// **********
	// Pin drive
	// **********
	initial begin
		tms_o = 1'h1;
		test_pin_o = 1'h0;
		blown_o = 1'h0;
	end

	task automatic drive(input logic tms, input logic pin, input logic blown);
		@(negedge clk_i);
		tms_o = tms;
		test_pin_o = pin;
		blown_o = blown;
	endtask : drive
endmodule : fcm_tool

// [tb_top.sv]
/*
 * Self-checking bench for the fuse check controller.
 * Assumes two cycles from a sampled pin change to the outputs.
 */
`timescale 1ns/1ps

module tb_top;
	logic clk_i = 1'h0;
	logic rst_n_i = 1'h0;
	logic tms, pin, blown, act, cur, byp, acc;
	int miscompares = 0;
	int checks_done = 0;

	fcm_tool tool (.clk_i(clk_i), .tms_o(tms), .test_pin_o(pin), .blown_o(blown));
	fcm_ctrl dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .tms_i(tms), .test_pin_i(pin),
		.fuse_blown_i(blown), .fuse_check_active_o(act), .fuse_check_current_o(cur),
		.debug_bypass_o(byp), .debug_access_en_o(acc));

	always #2.5 clk_i = ~clk_i;

	// **********
	// Helpers
	// **********
	// Expected order: active, current, bypass, access
	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %b want %b", $time, got, exp);
		end
	endtask : chk

	task automatic step(input logic t, input logic p, input logic b, input logic [3:0] exp);
		tool.drive(t, p, b);
		repeat (4) @(negedge clk_i);
		chk({act, cur, byp, acc}, exp);
	endtask : step

	task automatic rst(input logic t);
		tool.drive(t, 1'h0, 1'h0);
		rst_n_i = 1'h0;
		repeat (6) @(negedge clk_i);
		chk({act, cur, byp, acc}, 4'h1);
		rst_n_i = 1'h1;
	endtask : rst

	task automatic end_of_test;
		if (miscompares == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test

	// **********
	// Scenarios
	// **********
	task automatic t_walk;
		rst(1'h1);
		step(1'h0, 1'h0, 1'h0, 4'hd);
		step(1'h1, 1'h0, 1'h0, 4'h9);
		step(1'h0, 1'h0, 1'h0, 4'hd);
		step(1'h1, 1'h0, 1'h0, 4'h1);
		step(1'h0, 1'h0, 1'h0, 4'h1);
	endtask : t_walk

	task automatic t_held;
		rst(1'h0);
		repeat (4) @(negedge clk_i);
		chk({act, cur, byp, acc}, 4'hd);
		step(1'h1, 1'h0, 1'h0, 4'h9);
		step(1'h0, 1'h0, 1'h0, 4'hd);
		step(1'h1, 1'h0, 1'h0, 4'h1);
		rst(1'h1);
		step(1'h0, 1'h0, 1'h0, 4'hd);
	endtask : t_held

	task automatic t_pin;
		rst(1'h1);
		step(1'h0, 1'h1, 1'h0, 4'hd);
		step(1'h0, 1'h0, 1'h0, 4'h1);
	endtask : t_pin

	task automatic t_blow;
		rst(1'h1);
		step(1'h0, 1'h0, 1'h0, 4'hd);
		step(1'h0, 1'h0, 1'h1, 4'h2);
		step(1'h1, 1'h0, 1'h1, 4'h2);
		step(1'h0, 1'h0, 1'h1, 4'h2);
	endtask : t_blow

	initial begin
		t_walk();
		t_held();
		t_pin();
		t_blow();
		end_of_test();
	end

	initial begin
		repeat (2000) @(posedge clk_i);
		miscompares++;
		end_of_test();
	end
endmodule : tb_top
